// ===== design/siu_top.sv
`timescale 1ns/10ps
// ----------------------------------------
// subtract instruction unit
// ----------------------------------------
module siu_top (
  // clock and reset
  input  wire logic                  MCLK_I,
  input  wire logic                  RSTN_I,
  // instruction issue
  input  wire logic                  START_I,
  input  siu_pkg::siu_instr_t        INSTR_I,
  // mode and bank control
  input  wire logic                  EXT_MODE_I,
  input  wire logic [3:0]            BANK_PTR_I,
  input  wire logic [11:0]           INDEX_BASE_I,
  // data memory read port
  output logic [11:0]                RD_ADDR_O,
  input  wire logic [7:0]            RD_DATA_I,
  // data memory write port
  output logic [11:0]                WR_ADDR_O,
  output logic [7:0]                 WR_DATA_O,
  output logic                       WR_EN_O,
  // architectural state
  output logic [7:0]                 ACC_O,
  output logic [4:0]                 FLAGS_O,
  output logic                       BUSY_O,
  output logic                       DONE_O
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  // two-stage reset synchroniser
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  siu_pkg::siu_phase_t  phase_q, phase_d;
  siu_pkg::siu_instr_t  instr_q;
  logic                 busy_q;
  logic [7:0]           acc_q, acc_d;
  logic [4:0]           flags_q, flags_d;
  logic [7:0]           opnd_q;
  siu_pkg::siu_result_t res_q;
  logic [11:0]          rd_addr_q, rd_addr_d;
  logic [11:0]          wr_addr_q;
  logic [7:0]           wr_data_q;
  logic                 wr_en_q, wr_en_d;
  logic                 done_q, done_d;
  logic                 ext_q;
  logic [3:0]           bank_q;
  logic [11:0]          base_q;

  // ----------------------------------------
  // address resolution
  // ----------------------------------------
  function automatic logic [11:0] resolve_addr(
    input logic [7:0]  f,
    input logic        a,
    input logic        ext,
    input logic [3:0]  bank,
    input logic [11:0] base
  );
    logic [11:0] r;
    r = {bank, f};
    if (!a) begin
      if (ext && (f <= siu_pkg::IDX_LIMIT)) begin
        r = base + {4'h0, f};
      end else if (f < siu_pkg::ACC_SPLIT) begin
        r = {siu_pkg::LO_BANK, f};
      end else begin
        r = {siu_pkg::HI_BANK, f};
      end
    end
    return r;
  endfunction

  wire logic [11:0] file_addr =
    resolve_addr(instr_q.operand, instr_q.access, ext_q, bank_q, base_q);
  wire logic is_file =
    (instr_q.op == siu_pkg::SIU_FILE_MINUS_ACC_OP);
  wire logic is_lit =
    (instr_q.op == siu_pkg::SIU_LITERAL_MINUS_ACC_OP);
  wire logic take = START_I && !busy_q && (INSTR_I.op != siu_pkg::SIU_NOP);

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  siu_pkg::siu_result_t sub_res;

  // literal or file value minus accumulator
  siu_sub8 u_sub (
    .minuend_i    (opnd_q),
    .subtrahend_i (acc_q),
    .result_o     (sub_res)
  );

  // ----------------------------------------
  // phase sequencing
  // ----------------------------------------
  always_comb begin
    phase_d   = phase_q;
    acc_d     = acc_q;
    flags_d   = flags_q;
    rd_addr_d = rd_addr_q;
    wr_en_d   = 1'b0;
    done_d    = 1'b0;
    case (phase_q)
      siu_pkg::PH_DECODE: begin
        if (busy_q) begin
          phase_d = siu_pkg::PH_READ;
          if (is_file) begin
            rd_addr_d = file_addr;
          end
        end
      end
      siu_pkg::PH_READ: begin
        phase_d = siu_pkg::PH_PROCESS;
      end
      siu_pkg::PH_PROCESS: begin
        phase_d = siu_pkg::PH_WRITE;
      end
      siu_pkg::PH_WRITE: begin
        phase_d = siu_pkg::PH_DECODE;
        done_d  = 1'b1;
        flags_d = res_q.flags;
        if (is_lit || !instr_q.dest) begin
          acc_d = res_q.diff;
        end else begin
          wr_en_d = 1'b1;
        end
      end
      default: begin
        phase_d = siu_pkg::PH_DECODE;
      end
    endcase
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_q   <= siu_pkg::PH_DECODE;
      busy_q    <= 1'b0;
      acc_q     <= siu_pkg::ZERO_BYTE;
      flags_q   <= siu_pkg::FLAGS_RST;
      rd_addr_q <= 12'h000;
      wr_en_q   <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      phase_q   <= phase_d;
      acc_q     <= acc_d;
      flags_q   <= flags_d;
      rd_addr_q <= rd_addr_d;
      wr_en_q   <= wr_en_d;
      done_q    <= done_d;
      if (take) begin
        busy_q <= 1'b1;
      end else if (phase_q == siu_pkg::PH_WRITE) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // operand and result registers
  // ----------------------------------------
  always_ff @(posedge MCLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      instr_q   <= '0;
      opnd_q    <= siu_pkg::ZERO_BYTE;
      res_q     <= '0;
      wr_addr_q <= 12'h000;
      wr_data_q <= siu_pkg::ZERO_BYTE;
      ext_q     <= 1'b0;
      bank_q    <= 4'h0;
      base_q    <= 12'h000;
    end else begin
      if (take) begin
        instr_q <= INSTR_I;
        ext_q   <= EXT_MODE_I;
        bank_q  <= BANK_PTR_I;
        base_q  <= INDEX_BASE_I;
      end
      // read phase latches literal or memory data
      if (phase_q == siu_pkg::PH_READ) begin
        opnd_q <= is_file ? RD_DATA_I : instr_q.operand;
      end
      // process phase captures the difference
      if (phase_q == siu_pkg::PH_PROCESS) begin
        res_q <= sub_res;
      end
      if (phase_q == siu_pkg::PH_WRITE) begin
        wr_addr_q <= rd_addr_q;
        wr_data_q <= res_q.diff;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RD_ADDR_O = rd_addr_q;
  assign WR_ADDR_O = wr_addr_q;
  assign WR_DATA_O = wr_data_q;
  assign WR_EN_O   = wr_en_q;
  assign ACC_O     = acc_q;
  assign FLAGS_O   = flags_q;
  assign BUSY_O    = busy_q;
  assign DONE_O    = done_q;
endmodule

// ===== inc/siu_pkg.sv
package siu_pkg;
  localparam int          DW            = 8;
  localparam int          AW            = 12;
  localparam logic [7:0]  IDX_LIMIT     = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT     = 8'h60;
  localparam logic [3:0]  HI_BANK       = 4'hF;
  localparam logic [3:0]  LO_BANK       = 4'h0;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [4:0]  FLAGS_RST     = 5'h00;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_DC       = 1;
  localparam int          FLAG_Z        = 2;
  localparam int          FLAG_OV       = 3;
  localparam int          FLAG_N        = 4;

  typedef enum logic [1:0] {
    SIU_NOP,
    SIU_LITERAL_MINUS_ACC_OP,
    SIU_FILE_MINUS_ACC_OP
  } siu_op_t;

  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } siu_phase_t;

  typedef struct packed {
    siu_op_t    op;
    logic [7:0] operand;  // literal or file address
    logic       dest;
    logic       access;
  } siu_instr_t;

  typedef struct packed {
    logic [7:0] diff;
    logic [4:0] flags;
  } siu_result_t;
endpackage

// ===== design/siu_sub8.sv
`timescale 1ns/10ps
// ----------------------------------------
// subtractor: minuend minus subtrahend
// ----------------------------------------
module siu_sub8 (
  // operands
  input  wire logic [7:0]          minuend_i,
  input  wire logic [7:0]          subtrahend_i,
  // result and flags
  output siu_pkg::siu_result_t     result_o
);
  logic [8:0] full_sum;
  logic [4:0] half_sum;
  logic [7:0] diff;

  // add inverted subtrahend plus one, carry out means no borrow
  assign full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + 9'h001;
  assign half_sum = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]}
                    + 5'h01;
  assign diff     = full_sum[7:0];

  // flag packing
  assign result_o.diff                  = diff;
  assign result_o.flags[siu_pkg::FLAG_C]  = full_sum[8];
  assign result_o.flags[siu_pkg::FLAG_DC] = half_sum[4];
  assign result_o.flags[siu_pkg::FLAG_Z]  =
    (diff == siu_pkg::ZERO_BYTE);
  assign result_o.flags[siu_pkg::FLAG_OV] =
    (minuend_i[7] != subtrahend_i[7]) && (diff[7] != minuend_i[7]);
  assign result_o.flags[siu_pkg::FLAG_N]  = diff[7];
endmodule

// ===== tb/siu_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------
// subtract unit checker
// ----------------------------------------
module siu_monitor (
  // watched ports
  input wire logic           MCLK_I,
  input wire logic           RSTN_I,
  input wire logic           START_I,
  input siu_pkg::siu_instr_t INSTR_I,
  input wire logic           EXT_MODE_I,
  input wire logic [3:0]     BANK_PTR_I,
  input wire logic [11:0]    INDEX_BASE_I,
  input wire logic [11:0]    WR_ADDR_O,
  input wire logic           WR_EN_O,
  input wire logic [7:0]     ACC_O,
  input wire logic [4:0]     FLAGS_O,
  input wire logic           BUSY_O,
  input wire logic           DONE_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);
  // issue decode
  wire tk  = START_I && !BUSY_O && INSTR_I.op != siu_pkg::SIU_NOP;
  wire lit = tk && INSTR_I.op == siu_pkg::SIU_LITERAL_MINUS_ACC_OP;
  wire fil = tk && INSTR_I.op == siu_pkg::SIU_FILE_MINUS_ACC_OP;
  busy_span_a: assert property (tk |=> BUSY_O [*4] ##1 !BUSY_O)
    else $error("busy span wrong");
  done_time_a: assert property (tk |-> ##5 DONE_O)
    else $error("done late");
  lit_acc_a: assert property (lit |-> ##5 !WR_EN_O &&
    ACC_O == $past(INSTR_I.operand, 5) - $past(ACC_O, 5))
    else $error("literal result wrong");
  file_dest_a: assert property (fil |-> ##5 WR_EN_O == $past(INSTR_I.dest, 5))
    else $error("destination wrong");
  bank_addr_a: assert property (fil && INSTR_I.access && INSTR_I.dest
    |-> ##5 WR_ADDR_O == {$past(BANK_PTR_I, 5), $past(INSTR_I.operand, 5)})
    else $error("banked address wrong");
  access_bank_a: assert property (fil && !INSTR_I.access && INSTR_I.dest
    && !EXT_MODE_I |-> ##5 WR_ADDR_O[11:8] ==
    ($past(INSTR_I.operand, 5) >= siu_pkg::ACC_SPLIT ?
     siu_pkg::HI_BANK : siu_pkg::LO_BANK))
    else $error("access bank wrong");
  index_addr_a: assert property (fil && !INSTR_I.access && INSTR_I.dest
    && EXT_MODE_I && INSTR_I.operand <= siu_pkg::IDX_LIMIT |-> ##5
    WR_ADDR_O == $past(INDEX_BASE_I, 5) + {4'h0, $past(INSTR_I.operand, 5)})
    else $error("indexed address wrong");
  zero_neg_a: assert property (FLAGS_O[2] |-> !FLAGS_O[4])
    else $error("zero with negative");
  write_done_a: assert property (WR_EN_O |-> DONE_O)
    else $error("write outside completion");
  // main scenarios
  cover property (lit);
  cover property (fil && INSTR_I.dest);
  cover property (START_I && BUSY_O);
endmodule
bind siu_top siu_monitor u_siu_monitor (.MCLK_I, .RSTN_I, .START_I, .INSTR_I,
  .EXT_MODE_I, .BANK_PTR_I, .INDEX_BASE_I, .WR_ADDR_O, .WR_EN_O, .ACC_O,
  .FLAGS_O, .BUSY_O, .DONE_O);

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam siu_pkg::siu_op_t LIT = siu_pkg::SIU_LITERAL_MINUS_ACC_OP;
  localparam siu_pkg::siu_op_t FIL = siu_pkg::SIU_FILE_MINUS_ACC_OP;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic                clk = 1'b0, rst_n = 1'b0, start = 1'b0, ext = 1'b0;
  siu_pkg::siu_instr_t ins = '0;
  logic [3:0]          bank = 4'h0;
  logic [11:0]         base = 12'h000, rd_addr, wr_addr;
  logic [7:0]          wr_data, acc, s = 8'h40, m_acc = 8'h00, r8;
  logic [4:0]          flags;
  logic                wr_en, busy, done;
  logic [33:0]         q[$], e;
  logic [7:0]          kt[6] = '{8'h02, 8'h02, 8'h03, 8'h7F, 8'h80, 8'h00};
  logic [7:0]          ft[4] = '{8'h00, 8'h5F, 8'h60, 8'hFF};
  int                  err_count = 0, num_checks = 0;
  // memory image, combinational
  wire  [7:0]          rd_data = rd_addr[7:0] ^ {rd_addr[11:8], 4'h5};
  always #50 clk = ~clk;
  siu_top u_siu_top (
    .MCLK_I(clk), .RSTN_I(rst_n), .START_I(start), .INSTR_I(ins),
    .EXT_MODE_I(ext), .BANK_PTR_I(bank), .INDEX_BASE_I(base),
    .RD_ADDR_O(rd_addr), .RD_DATA_I(rd_data), .WR_ADDR_O(wr_addr),
    .WR_DATA_O(wr_data), .WR_EN_O(wr_en), .ACC_O(acc), .FLAGS_O(flags),
    .BUSY_O(busy), .DONE_O(done)
  );
  function automatic logic [7:0] rnd();
    s = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    return s;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("Error %0t: %s", $time, m);
  endtask
  // bounded wait for idle
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      @(posedge clk);
      #5;
      if (++n > 20) begin
        fail("busy stuck");
        print_verdict();
      end
    end
  endtask
  // note expected outcome, then issue
  task automatic run(input siu_pkg::siu_op_t op, input logic [7:0] k,
                     input logic d, input logic a);
    logic [11:0] ad;
    logic [7:0]  mv, r;
    logic [4:0]  f;
    logic        w;
    wait_idle();
    ad = a ? {bank, k} : (ext && k <= siu_pkg::IDX_LIMIT) ? base + 12'(k)
       : {((k >= siu_pkg::ACC_SPLIT) ? siu_pkg::HI_BANK : siu_pkg::LO_BANK), k};
    mv = (op == FIL) ? ad[7:0] ^ {ad[11:8], 4'h5} : k;
    r = mv - m_acc;
    f = {r[7], mv[7] != m_acc[7] && r[7] != mv[7], r == 8'h00,
         mv[3:0] >= m_acc[3:0], mv >= m_acc};
    w = d && op == FIL;
    if (!w) m_acc = r;
    q.push_back({m_acc, f, w, ad, r});
    ins = '{op, k, d, a};
    start = 1'b1;
    @(posedge clk);
    #5 start = 1'b0;
  endtask
  // result watcher
  always @(posedge clk) begin
    #1;
    if (done === 1'b1) begin
      num_checks++;
      if (q.size() == 0) fail("unexpected completion");
      else begin
        e = q.pop_front();
        if ({acc, flags, wr_en} !== e[33:20] ||
            (e[20] && {wr_addr, wr_data} !== e[19:0])) fail("result");
      end
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #5 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    #5;
    foreach (kt[i]) run(LIT, kt[i], 1'b0, 1'b0);
    $display("test literal edges done");
    for (int i = 0; i < 32; i++) begin
      ext = i[4];
      bank = 4'(rnd());
      base = {4'h0, rnd()};
      run(FIL, ft[i[1:0]], i[2], i[3]);
    end
    $display("test file modes done");
    for (int i = 0; i < 40; i++) begin
      r8 = rnd();
      ext = r8[0];
      if (r8[1]) run(FIL, rnd(), r8[2], r8[3]);
      else run(LIT, rnd(), r8[2], r8[3]);
    end
    $display("test random done");
    run(LIT, 8'h11, 1'b0, 1'b0);
    @(posedge clk);
    #5 start = 1'b1;
    ins.op = FIL;
    repeat (2) @(posedge clk);
    #5 ins.op = siu_pkg::SIU_NOP;
    repeat (6) @(posedge clk);
    #5 start = 1'b0;
    wait_idle();
    repeat (6) @(posedge clk);
    #5 if (q.size() != 0) fail("missing completion");
    $display("test refusal done");
    print_verdict();
  end
endmodule
